// >>> core/tcps_pkg.sv
// How it works
// RL1: counter off with oscillator enable clear leaves both shared pins as ordinary port I/O; code still takes port bit 1 while source select is set.
// RL2: timer mode counts main clock divided by four; pins stay ordinary I/O while oscillator enable is clear.
// RL3: external counter mode counts edges of the clock input pin.
// RL4: external counter mode, clock-pin data bit reads the pin level.
// RL5: firmware mode drives clock pin from data bit 0 and counts it.
// RL6: firmware mode clock-pin data bit reads and writes through to the pin.
// RL7: external or firmware clocking, port bit 1 reads zero as input.
// RL8: those modes, port bit 1 as output reads latch; writes stay latched.
// RL9: clearing clock-source select drives port pin 1 from its latch again.
// RL10: oscillator enable plus external source turns both pins into crystal oscillator.
// RL11: crystal mode, clock-pin data bit reads zero, writes never reach pin.
// RL12: crystal mode, port bits 2:1 read zero as inputs, latches as outputs.
// RL13: source select and oscillator enable both clear drive pins 2:1 from latches.
// RL14: crystal oscillator enabled only while control bit 3 is set.
// RL15: enabled crystal oscillator keeps running during sleep.
// RL16: software waits for oscillator start-up before trusting the count.
// RL17: count runs 0000h to FFFFh then rolls over to 0000h.
// RL18: overflow sets and holds the overflow flag, flag register bit 0.
// RL19: overflow interrupt raised only while enable register bit 0 is set.
// RL20: run bit starts counting when set and stops it when cleared.
// RL21: control bits 5..0: prescale(2), osc enable, sync, source select, run.
// RL22: flag stays set until software writes zero; set beats clear.
package tcps_pkg;
  localparam int CTRL_W      = 6;
  localparam int CNT_W       = 16;
  localparam int ON_BIT      = 0;
  localparam int CS_BIT      = 1;
  localparam int SYNC_BIT    = 2;
  localparam int OSCEN_BIT   = 3;
  localparam int PS_LSB      = 4;
  localparam int PS_W        = 2;
  localparam int FLAG_BIT    = 0;
  localparam int IE_BIT      = 0;
  localparam int INSN_DIV    = 4;
  localparam int PRE_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
  localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 16'hFFFF;
  localparam logic [1:0]        DIV_LAST  = 2'(INSN_DIV - 1);
  localparam logic [1:0]        LATCH_RST = 2'h0;
  typedef enum logic [2:0] {MODE_OFF, MODE_TIMER, MODE_EXT, MODE_FW, MODE_XTAL} tcps_mode_t;
endpackage

// >>> core/tcps_sync.sv
`timescale 1ns/1ns
module tcps_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  logic             mclk_i,
  input  logic             nrst_i,
  // asynchronous levels in, synchronised level and rising edge out
  input  logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;
  logic [WIDTH-1:0] next_prev;

  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
    next_prev   = stage2;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      prev   <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      prev   <= next_prev;
    end
  end

  assign level_o = stage2;
  assign rise_o  = stage2 & ~prev;
endmodule // tcps_sync

// >>> core/tcps_timer.sv
`timescale 1ns/1ns
module tcps_timer (
  // clock and reset
  input  logic                        mclk_i,
  input  logic                        nrst_i,
  // timer control register
  input  logic                        ctrl_wr_i,
  input  logic [tcps_pkg::CTRL_W-1:0] ctrl_wdata_i,
  output logic [tcps_pkg::CTRL_W-1:0] ctrl_o,
  // sixteen bit count
  input  logic                        cnt_wr_i,
  input  logic [tcps_pkg::CNT_W-1:0]  cnt_wdata_i,
  output logic [tcps_pkg::CNT_W-1:0]  cnt_o,
  // clock pin data bit and its direction
  input  logic                        pdat_wr_i,
  input  logic                        pdat_wdata_i,
  input  logic                        clk_pin_dir_i,
  output logic                        pdat_rdata_o,
  // general port b bits 2:1, index 0 is bit 1
  input  logic                        general_port_b_wr_i,
  input  logic [1:0]                  general_port_b_wdata_i,
  input  logic [1:0]                  general_port_b_dir_i,
  output logic [1:0]                  general_port_b_rdata_o,
  // overflow flag and enable
  input  logic                        flag_wr_i,
  input  logic                        flag_wdata_i,
  input  logic                        ovf_irq_en_i,
  output logic                        flag_o,
  output logic                        irq_o,
  // sleep and crystal oscillator
  input  logic                        sleep_i,
  input  logic                        osc_clk_i,
  output logic                        osc_enable_o,
  // clock pin, port bit 1
  input  logic                        clk_pin_i,
  output logic                        clk_pin_o,
  output logic                        clk_pin_oe_o,
  // crystal in pin, port bit 2
  input  logic                        xtal_pin_i,
  output logic                        xtal_pin_o,
  output logic                        xtal_pin_oe_o
);
  import tcps_pkg::*;

  function automatic tcps_mode_t decode_mode(input logic [CTRL_W-1:0] c, input logic dir);
    tcps_mode_t m;
    m = MODE_OFF;
    if (c[OSCEN_BIT] && c[CS_BIT]) begin
      m = MODE_XTAL;
    end else if (c[CS_BIT]) begin
      m = dir ? MODE_EXT : MODE_FW;
    end else if (c[ON_BIT]) begin
      m = MODE_TIMER;
    end
    return m;
  endfunction

  function automatic logic [PRE_W-1:0] presc_limit(input logic [PS_W-1:0] ps);
    return PRE_W'((1 << ps) - 1);
  endfunction

  // synchronised pins and oscillator
  logic [2:0] s_level;
  logic [2:0] s_rise;

  tcps_sync #(
    .WIDTH (3)
  ) i_tcps_sync (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i ({osc_clk_i, xtal_pin_i, clk_pin_i}),
    .level_o (s_level),
    .rise_o  (s_rise)
  );

  // control state
  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]  cnt;
  logic [PRE_W-1:0]  presc;
  logic [1:0]        div;
  logic              flag;
  logic              pdat;
  logic              pdat_prev;
  logic [1:0]        latch;
  logic [CTRL_W-1:0] next_ctrl;
  logic [CNT_W-1:0]  next_cnt;
  logic [PRE_W-1:0]  next_presc;
  logic [1:0]        next_div;
  logic              next_flag;
  logic              next_pdat;
  logic              next_pdat_prev;
  logic [1:0]        next_latch;
  tcps_mode_t        mode;
  logic              osc_owns;
  logic              src_tick;
  logic              inc;
  logic              ovf;

  assign mode     = decode_mode(ctrl, clk_pin_dir_i);
  assign osc_owns = ctrl[OSCEN_BIT];

  always_comb begin
    next_div = div + 2'h1;
    case (mode)
      MODE_TIMER: src_tick = (div == DIV_LAST) && !sleep_i; // RL2
      MODE_EXT:   src_tick = s_rise[0];                     // RL3
      MODE_FW:    src_tick = pdat && !pdat_prev;            // RL5
      MODE_XTAL:  src_tick = s_rise[2];                     // RL10
      default:    src_tick = 1'b0;
    endcase
  end

  always_comb begin
    next_ctrl  = ctrl_wr_i ? ctrl_wdata_i : ctrl; // RL21
    next_presc = presc;
    inc        = 1'b0;
    if (ctrl_wr_i || !ctrl[ON_BIT]) begin
      next_presc = '0;
    end else if (src_tick) begin // RL20
      if (presc == presc_limit(ctrl[PS_LSB +: PS_W])) begin
        next_presc = '0;
        inc        = 1'b1;
      end else begin
        next_presc = presc + PRE_W'(1);
      end
    end
  end

  always_comb begin
    ovf      = inc && (cnt == CNT_MAX); // RL17
    next_cnt = cnt;
    if (cnt_wr_i) begin
      next_cnt = cnt_wdata_i;
    end else if (inc) begin
      next_cnt = cnt + CNT_W'(1); // RL17
    end
    next_flag = ovf || (flag && !(flag_wr_i && !flag_wdata_i)); // RL18 RL22
  end

  always_comb begin
    next_pdat      = pdat_wr_i ? pdat_wdata_i : pdat; // RL6
    next_pdat_prev = pdat;
    next_latch     = general_port_b_wr_i ? general_port_b_wdata_i : latch; // RL8 RL12
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl      <= CTRL_RST;
      cnt       <= CNT_RST;
      presc     <= '0;
      div       <= '0;
      flag      <= 1'b0;
      pdat      <= 1'b0;
      pdat_prev <= 1'b0;
      latch     <= LATCH_RST;
    end else begin
      ctrl      <= next_ctrl;
      cnt       <= next_cnt;
      presc     <= next_presc;
      div       <= next_div;
      flag      <= next_flag;
      pdat      <= next_pdat;
      pdat_prev <= next_pdat_prev;
      latch     <= next_latch;
    end
  end

  // pin drive and read back
  logic       pin1_o;
  logic       pin1_oe;
  logic       pin2_o;
  logic       pin2_oe;
  logic [1:0] prd;
  logic       pdrd;
  logic       next_pin1_o;
  logic       next_pin1_oe;
  logic       next_pin2_o;
  logic       next_pin2_oe;
  logic [1:0] next_prd;
  logic       next_pdrd;

  always_comb begin
    next_pin1_o  = latch[0];
    next_pin1_oe = !general_port_b_dir_i[0];
    next_pin2_o  = latch[1];
    next_pin2_oe = !general_port_b_dir_i[1];
    next_prd[0]  = general_port_b_dir_i[0] ? s_level[0] : latch[0];
    next_prd[1]  = general_port_b_dir_i[1] ? s_level[1] : latch[1];
    next_pdrd    = pdat;
    if (osc_owns) begin
      next_pin1_oe = 1'b0; // RL10 RL11
      next_pin2_oe = 1'b0; // RL12
      next_prd[0]  = general_port_b_dir_i[0] ? 1'b0 : latch[0]; // RL12
      next_prd[1]  = general_port_b_dir_i[1] ? 1'b0 : latch[1]; // RL12
      next_pdrd    = 1'b0; // RL11
    end else if (ctrl[CS_BIT]) begin
      next_prd[0]  = general_port_b_dir_i[0] ? 1'b0 : latch[0]; // RL7 RL8
      if (clk_pin_dir_i) begin
        next_pin1_oe = 1'b0;
        next_pdrd    = s_level[0]; // RL4
      end else begin
        next_pin1_oe = 1'b1; // RL5
        next_pin1_o  = pdat; // RL6
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin1_o  <= 1'b0;
      pin1_oe <= 1'b0;
      pin2_o  <= 1'b0;
      pin2_oe <= 1'b0;
      prd     <= 2'h0;
      pdrd    <= 1'b0;
    end else begin
      pin1_o  <= next_pin1_o;  // RL1 RL9 RL13
      pin1_oe <= next_pin1_oe;
      pin2_o  <= next_pin2_o;  // RL13
      pin2_oe <= next_pin2_oe;
      prd     <= next_prd;
      pdrd    <= next_pdrd;
    end
  end

  assign ctrl_o        = ctrl;
  assign cnt_o         = cnt;
  assign flag_o        = flag;
  assign irq_o         = flag && ovf_irq_en_i; // RL19
  assign osc_enable_o  = ctrl[OSCEN_BIT];      // RL14 RL15
  assign pdat_rdata_o  = pdrd;
  assign general_port_b_rdata_o = prd;
  assign clk_pin_o     = pin1_o;
  assign clk_pin_oe_o  = pin1_oe;
  assign xtal_pin_o    = pin2_o;
  assign xtal_pin_oe_o = pin2_oe;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  logic tmr_run;
  logic ext_run;
  assign tmr_run = (mode == MODE_TIMER) && ctrl[PS_LSB +: PS_W] == '0 && !sleep_i
                   && !cnt_wr_i && !ctrl_wr_i;
  assign ext_run = (mode == MODE_EXT) && ctrl[ON_BIT] && ctrl[PS_LSB +: PS_W] == '0
                   && !cnt_wr_i && !ctrl_wr_i;

  sequence tmr_window_s;
    tmr_run [*4];
  endsequence

  sequence ext_edge_s;
    ext_run && s_rise[0];
  endsequence

  count_wrap_a: assert property (inc && !cnt_wr_i && cnt == CNT_MAX |=> cnt == CNT_RST) // RL17
    else $error("count did not roll over to zero");
  flag_set_a: assert property (ovf |=> flag_o) // RL18
    else $error("overflow did not set flag");
  flag_hold_a: assert property (flag_o && !(flag_wr_i && !flag_wdata_i) |=> flag_o) // RL22
    else $error("flag dropped without a zero write");
  irq_gate_a: assert property (irq_o == (flag_o && ovf_irq_en_i)) // RL19
    else $error("interrupt not gated by enable");
  osc_enable_a: assert property (ctrl_wr_i |=> osc_enable_o == $past(ctrl_wdata_i[OSCEN_BIT])) // RL14
    else $error("oscillator enable does not follow control bit");
  count_stop_a: assert property (!ctrl[ON_BIT] && !cnt_wr_i |=> $stable(cnt_o)) // RL20
    else $error("count moved while stopped");
  timer_rate_a: assert property (tmr_window_s |=> cnt_o == CNT_W'($past(cnt_o, 4) + 1)) // RL2
    else $error("timer mode not counting at one quarter rate");
  ext_count_a: assert property (ext_edge_s |=> cnt_o == CNT_W'($past(cnt_o) + 1)) // RL3
    else $error("external edge not counted");
  ext_read_a: assert property ((mode == MODE_EXT) && !osc_owns |=> pdat_rdata_o == $past(s_level[0])) // RL4
    else $error("data bit does not show clock pin level");
  fw_drive_a: assert property ((mode == MODE_FW) |=> clk_pin_oe_o && clk_pin_o == $past(pdat)) // RL5
    else $error("firmware clock not driven on pin");
  port_zero_a: assert property (ctrl[CS_BIT] && general_port_b_dir_i[0] |=> general_port_b_rdata_o[0] == 1'b0) // RL7
    else $error("port bit 1 input not read as zero");
  xtal_pins_a: assert property (osc_owns |=> !clk_pin_oe_o && !xtal_pin_oe_o && !pdat_rdata_o) // RL11
    else $error("crystal mode pins driven or data bit nonzero");
  latch_drive_a: assert property (!ctrl[CS_BIT] && !osc_owns && !general_port_b_dir_i[0]
                                  |=> clk_pin_oe_o && clk_pin_o == $past(latch[0])) // RL9
    else $error("port pin 1 not driven from latch");

  // counting in the pin clocked modes and during sleep
  logic xtal_run;
  logic fw_run;
  assign xtal_run = (mode == MODE_XTAL) && ctrl[ON_BIT] && ctrl[PS_LSB +: PS_W] == '0
                    && !cnt_wr_i && !ctrl_wr_i;
  assign fw_run   = (mode == MODE_FW) && ctrl[ON_BIT] && ctrl[PS_LSB +: PS_W] == '0
                    && !cnt_wr_i && !ctrl_wr_i;

  sequence xtal_edge_s;
    xtal_run && s_rise[2];
  endsequence

  sequence fw_edge_s;
    fw_run && pdat && !pdat_prev;
  endsequence

  xtal_count_a: assert property (xtal_edge_s |=> cnt_o == CNT_W'($past(cnt_o) + 1)) // RL10
    else $error("crystal edge not counted");
  fw_count_a: assert property (fw_edge_s |=> cnt_o == CNT_W'($past(cnt_o) + 1)) // RL5
    else $error("firmware edge not counted");
  sleep_gate_a: assert property ((mode == MODE_TIMER) && sleep_i && !cnt_wr_i
                                 |=> $stable(cnt_o)) // RL2
    else $error("timer mode counted during sleep");
  osc_sleep_a: assert property (osc_owns && sleep_i |-> osc_enable_o) // RL15
    else $error("oscillator stopped during sleep");

  // loads and flag clearing
  ctrl_load_a: assert property (ctrl_wr_i |=> ctrl_o == $past(ctrl_wdata_i)) // RL21
    else $error("control write not stored");
  cnt_load_a: assert property (cnt_wr_i |=> cnt_o == $past(cnt_wdata_i)) // RL17
    else $error("count load not taken");
  flag_clear_a: assert property (flag_o && flag_wr_i && !flag_wdata_i && !ovf |=> !flag_o) // RL22
    else $error("zero write did not clear flag");

  // shared port bits
  port_read_a: assert property (!ctrl[CS_BIT] && !osc_owns && general_port_b_dir_i[0]
                                |=> general_port_b_rdata_o[0] == $past(s_level[0])) // RL1
    else $error("port bit 1 input not read from pin");
  off_pins_a: assert property (!ctrl[CS_BIT] && !osc_owns && !general_port_b_dir_i[1]
                               |=> xtal_pin_oe_o && xtal_pin_o == $past(latch[1])) // RL13
    else $error("port pin 2 not driven from latch");
  port_latch_a: assert property (ctrl[CS_BIT] && !general_port_b_dir_i[0]
                                 |=> general_port_b_rdata_o[0] == $past(latch[0])) // RL8
    else $error("port bit 1 output not read from latch");
  fw_read_a: assert property ((mode == MODE_FW) |=> pdat_rdata_o == $past(pdat)) // RL6
    else $error("firmware data bit not read back");
  xtal_zero_a: assert property (osc_owns && general_port_b_dir_i[1] |=> general_port_b_rdata_o[1] == 1'b0) // RL12
    else $error("port bit 2 input not read as zero");
  xtal_latch_a: assert property (osc_owns && !general_port_b_dir_i[1]
                                 |=> general_port_b_rdata_o[1] == $past(latch[1])) // RL12
    else $error("port bit 2 output not read from latch");
endmodule // tcps_timer

// >>> verif/tcps_timer_test.sv
`timescale 1ns/1ns
module tcps_timer_test;
  import tcps_pkg::*;
  typedef struct packed {
    logic [5:0] ctrl;
    logic       cdir;
    logic [1:0] pbdir;
    logic [1:0] latch;
    logic       pdat;
    logic [6:0] exp;
  } tcps_row_t;
  localparam int CTRL = 0, CNT = 1, PDAT = 2, GENERAL_PORT_B = 3, FLAG = 4;
  // driven inputs
  logic              mclk_i = 1'b0, nrst_i = 1'b0, clk_pin_dir_i = 1'b1;
  logic              ctrl_wr_i = 1'b0, cnt_wr_i = 1'b0, pdat_wr_i = 1'b0;
  logic              general_port_b_wr_i = 1'b0, flag_wr_i = 1'b0, pdat_wdata_i = 1'b0;
  logic              flag_wdata_i = 1'b0, ovf_irq_en_i = 1'b1, sleep_i = 1'b0;
  logic              osc_clk_i = 1'b0, clk_pin_i = 1'b1, xtal_pin_i = 1'b1;
  logic [CTRL_W-1:0] ctrl_wdata_i = 6'h00;
  logic [CNT_W-1:0]  cnt_wdata_i = 16'h0000;
  logic [1:0]        general_port_b_wdata_i = 2'h0, general_port_b_dir_i = 2'h3;
  // observed outputs
  logic [CTRL_W-1:0] ctrl_o;
  logic [CNT_W-1:0]  cnt_o, hold;
  logic [1:0]        general_port_b_rdata_o;
  logic              pdat_rdata_o, flag_o, irq_o, osc_enable_o;
  logic              clk_pin_o, clk_pin_oe_o, xtal_pin_o, xtal_pin_oe_o;
  int                failures = 0, n_checks = 0;
  // pin mode table: exp = {port read, clk oe, xtal oe, data bit read, clk out, xtal out}
  tcps_row_t rows [9] = '{
    '{6'h00, 1'h0, 2'h0, 2'h2, 1'h1, 7'h5d},
    '{6'h01, 1'h0, 2'h0, 2'h2, 1'h1, 7'h5d},
    '{6'h00, 1'h1, 2'h3, 2'h0, 1'h0, 7'h60},
    '{6'h03, 1'h1, 2'h3, 2'h3, 1'h0, 7'h44},
    '{6'h03, 1'h1, 2'h0, 2'h1, 1'h0, 7'h2c},
    '{6'h03, 1'h0, 2'h3, 2'h0, 1'h1, 7'h56},
    '{6'h0b, 1'h1, 2'h3, 2'h0, 1'h1, 7'h00},
    '{6'h0b, 1'h0, 2'h0, 2'h3, 1'h1, 7'h60},
    '{6'h00, 1'h0, 2'h0, 2'h3, 1'h1, 7'h7f}};

  always #5 mclk_i = ~mclk_i;

  tcps_timer i_tcps_timer (
    .mclk_i        (mclk_i),
    .nrst_i        (nrst_i),
    .ctrl_wr_i     (ctrl_wr_i),
    .ctrl_wdata_i  (ctrl_wdata_i),
    .ctrl_o        (ctrl_o),
    .cnt_wr_i      (cnt_wr_i),
    .cnt_wdata_i   (cnt_wdata_i),
    .cnt_o         (cnt_o),
    .pdat_wr_i     (pdat_wr_i),
    .pdat_wdata_i  (pdat_wdata_i),
    .clk_pin_dir_i (clk_pin_dir_i),
    .pdat_rdata_o  (pdat_rdata_o),
    .general_port_b_wr_i    (general_port_b_wr_i),
    .general_port_b_wdata_i (general_port_b_wdata_i),
    .general_port_b_dir_i   (general_port_b_dir_i),
    .general_port_b_rdata_o (general_port_b_rdata_o),
    .flag_wr_i     (flag_wr_i),
    .flag_wdata_i  (flag_wdata_i),
    .ovf_irq_en_i  (ovf_irq_en_i),
    .flag_o        (flag_o),
    .irq_o         (irq_o),
    .sleep_i       (sleep_i),
    .osc_clk_i     (osc_clk_i),
    .osc_enable_o  (osc_enable_o),
    .clk_pin_i     (clk_pin_i),
    .clk_pin_o     (clk_pin_o),
    .clk_pin_oe_o  (clk_pin_oe_o),
    .xtal_pin_i    (xtal_pin_i),
    .xtal_pin_o    (xtal_pin_o),
    .xtal_pin_oe_o (xtal_pin_oe_o)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int sel, input logic [15:0] v);
    @(posedge mclk_i);
    ctrl_wdata_i <= v[5:0];
    cnt_wdata_i <= v;
    pdat_wdata_i <= v[0];
    general_port_b_wdata_i <= v[1:0];
    flag_wdata_i <= v[0];
    ctrl_wr_i <= (sel == CTRL);
    cnt_wr_i <= (sel == CNT);
    pdat_wr_i <= (sel == PDAT);
    general_port_b_wr_i <= (sel == GENERAL_PORT_B);
    flag_wr_i <= (sel == FLAG);
    @(posedge mclk_i);
    {ctrl_wr_i, cnt_wr_i, pdat_wr_i, general_port_b_wr_i, flag_wr_i} <= 5'h00;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (2) @(negedge mclk_i);
    check({cnt_o[9:0], ctrl_o}, 16'h0000);
    check({flag_o, irq_o, osc_enable_o, clk_pin_oe_o, xtal_pin_oe_o}, 16'h0000);
    cyc(2);
    nrst_i <= 1'b1;
    $display("reset test done");
    // pin sharing per mode
    foreach (rows[i]) begin
      wr(GENERAL_PORT_B, {14'h0000, rows[i].latch});
      wr(PDAT, {15'h0000, rows[i].pdat});
      clk_pin_dir_i <= rows[i].cdir;
      general_port_b_dir_i <= rows[i].pbdir;
      wr(CTRL, {10'h000, rows[i].ctrl});
      cyc(6);
      @(negedge mclk_i);
      check({9'h000, general_port_b_rdata_o, clk_pin_oe_o, xtal_pin_oe_o, pdat_rdata_o,
             clk_pin_o & clk_pin_oe_o, xtal_pin_o & xtal_pin_oe_o},
            {9'h000, rows[i].exp});
      $display("mode row %0d done", i);
    end
    // timer mode rollover, rate and flag
    wr(CNT, 16'hfffe);
    wr(CTRL, 16'h0001);
    @(negedge mclk_i);
    check({15'h0000, flag_o}, 16'h0000);
    for (int i = 0; i < 40 && cnt_o !== 16'h0000; i++) @(negedge mclk_i);
    check(cnt_o, 16'h0000);
    check({14'h0000, flag_o, irq_o}, 16'h0003);
    repeat (40) @(negedge mclk_i);
    check(cnt_o, 16'h000a);
    @(posedge mclk_i);
    ovf_irq_en_i <= 1'b0;
    @(negedge mclk_i);
    check({14'h0000, flag_o, irq_o}, 16'h0002);
    @(posedge mclk_i);
    ovf_irq_en_i <= 1'b1;
    wr(FLAG, 16'h0001);
    @(negedge mclk_i);
    check({15'h0000, flag_o}, 16'h0001);
    wr(FLAG, 16'h0000);
    @(negedge mclk_i);
    check({15'h0000, flag_o, irq_o}, 16'h0000);
    wr(CTRL, 16'h0035);
    @(negedge mclk_i);
    check({10'h000, ctrl_o}, 16'h0035);
    wr(CTRL, 16'h0000);
    @(negedge mclk_i);
    hold = cnt_o;
    repeat (20) @(negedge mclk_i);
    check(cnt_o, hold);
    $display("timer test done");
    // external pin clock
    @(posedge mclk_i);
    clk_pin_dir_i <= 1'b1;
    clk_pin_i <= 1'b0;
    wr(CTRL, 16'h0003);
    wr(CNT, 16'h0000);
    repeat (5) begin
      cyc(4);
      clk_pin_i <= 1'b1;
      cyc(4);
      clk_pin_i <= 1'b0;
    end
    cyc(6);
    @(negedge mclk_i);
    check(cnt_o, 16'h0005);
    $display("external clock test done");
    // firmware toggled data bit
    @(posedge mclk_i);
    clk_pin_dir_i <= 1'b0;
    wr(PDAT, 16'h0000);
    wr(CNT, 16'h0000);
    repeat (3) begin
      wr(PDAT, 16'h0001);
      cyc(3);
      wr(PDAT, 16'h0000);
      cyc(3);
    end
    @(negedge mclk_i);
    check(cnt_o, 16'h0003);
    $display("firmware clock test done");
    // crystal clock through sleep
    @(posedge mclk_i);
    sleep_i <= 1'b1;
    clk_pin_dir_i <= 1'b1;
    wr(CTRL, 16'h000b);
    cyc(8);
    wr(CNT, 16'h0000);
    repeat (4) begin
      cyc(4);
      osc_clk_i <= 1'b1;
      cyc(4);
      osc_clk_i <= 1'b0;
    end
    cyc(6);
    @(negedge mclk_i);
    check(cnt_o, 16'h0004);
    check({15'h0000, osc_enable_o}, 16'h0001);
    wr(CTRL, 16'h0002);
    @(negedge mclk_i);
    check({15'h0000, osc_enable_o}, 16'h0000);
    $display("crystal test done");
    end_of_test();
  end
endmodule // tcps_timer_test
